// ---- include/lfcs_pkg.sv ----
package lfcs_pkg;
  // Register addresses on the command port
  localparam logic [3:0] LFCS_ADDR_CFG5 = 4'h5;
  localparam logic [3:0] LFCS_ADDR_COLCHK = 4'h6;
  localparam logic [3:0] LFCS_ADDR_STATUS = 4'h7;
  localparam int LFCS_W = 9;
  localparam int LFCS_LOWER_REGS = 5;
  // Configuration register 5 fields, row check bit and top column check bit
  localparam int LFCS_AUTO_BIT = 8;
  localparam int LFCS_GATE_BIT = 7;
  localparam int LFCS_DEPTH_HI = 6;
  localparam int LFCS_DEPTH_LO = 5;
  localparam int LFCS_ZCUT_HI = 4;
  localparam int LFCS_ZCUT_LO = 1;
  localparam int LFCS_ROW_BIT = 0;
  localparam int LFCS_COL_TOP = 8;
  // Configuration register 0 fields used here
  localparam int LFCS_ALERT_SEL_BIT = 4;
  localparam int LFCS_EN_HI = 3;
  localparam int LFCS_EN_LO = 1;
  localparam logic [8:0] LFCS_CFG5_RST = 9'h000;
  localparam logic [8:0] LFCS_COLCHK_RST = 9'h000;
  localparam logic [8:0] LFCS_STATUS_RST = 9'h001;
  localparam logic [8:0] LFCS_READ_ZERO = 9'h000;
  // Minimum modulation depth codes, in percent
  localparam logic [1:0] LFCS_DEPTH_C50 = 2'h0;
  localparam logic [1:0] LFCS_DEPTH_C75 = 2'h1;
  localparam logic [1:0] LFCS_DEPTH_C25 = 2'h2;
  localparam logic [6:0] LFCS_PCT_50 = 7'h32;
  localparam logic [6:0] LFCS_PCT_75 = 7'h4b;
  localparam logic [6:0] LFCS_PCT_25 = 7'h19;
  localparam logic [6:0] LFCS_PCT_12 = 7'h0c;
  localparam int LFCS_DB_PER_STEP = 2;
  localparam int LFCS_SYNC_W = 13;

  typedef struct packed {
    logic z_channel_passing;
    logic y_channel_passing;
    logic x_channel_passing;
    logic gain_loop_active;
    logic z_woke_front_end;
    logic y_woke_front_end;
    logic x_woke_front_end;
    logic alarm;
    logic check_error_flag;
  } lfcs_status_s;

  typedef struct packed {
    logic [2:0] demod_high;
    logic [2:0] chan_data;
    logic gain_regulating;
    logic gain_settled;
    logic [2:0] wake_hit;
    logic alarm_expired;
    logic stab_done;
  } lfcs_pins_s;
endpackage

// ---- rtl/lfcs_regs.sv ----
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1: Auto pick keeps channels whose demodulator is high at stabilization end.
// R2: Gating flag withholds demodulated output until the gain loop regulates.
// R3: Depth code 00=50%, 01=75%, 10=25%, 11=12%.
// R4: Z sensitivity cut is a monotonic 2 dB step code, 0 to 30 dB.
// R5: Host makes every 9-bit configuration word hold odd ones.
// R6: Host sets low column check bits odd across registers 0 to 5.
// R7: Host sets top column check bit odd with the row check bits of registers 0 to 5.
// R8: Channel passing flags high while channel passes data, low in standby.
// R9: Gain loop active flag follows the regulating gain loop in real time.
// R10: Wake flag set when that channel woke the front end.
// R11: Alarm flag set on alarm timer expiry; may drive alert low.
// R12: Parity error shown live in status and drives alert low.
// R13: Power-on reset clears status except the parity error flag.
// R14: Status read clears only alarm; sleep changes no status bit.
// R15: Soft reset clears passing, gain and wake flags, keeps alarm, error.
// R16: Configuration registers read and write; status writes ignored.
// R17: Alert source select adds alarm to parity error as alert cause.
// R18: Row and column odd parity checked continuously over registers 0 to 6.
module lfcs_regs
  import lfcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [3:0] addr,
  input wire logic [8:0] wr_data,
  output logic [8:0] rd_data,
  input wire logic [LFCS_LOWER_REGS-1:0][8:0] lower_cfg,
  input wire logic soft_reset,
  input wire logic sleep_cmd,
  input wire logic standby,
  input wire lfcs_pins_s pins,
  output logic [2:0] channel_keep,
  output logic demod_out_enable,
  output logic [6:0] min_depth_pct,
  output logic [4:0] z_cut_db,
  output logic alert_n,
  output lfcs_status_s status
);
  logic [8:0] front_end_config_five;
  logic [8:0] column_check_bits;
  logic [8:0] next_cfg5;
  logic [8:0] next_col;
  logic [8:0] next_rd_data;
  lfcs_pins_s sync1;
  lfcs_pins_s sync2;
  lfcs_pins_s sync_prev;
  logic [2:0] next_keep;
  lfcs_status_s next_status;
  logic [2:0] wake_rise;
  logic alarm_rise;
  logic stab_rise;
  logic status_read;
  logic parity_bad;
  logic [6:0] next_pct;
  logic [4:0] next_cut;
  logic auto_channel_pick;
  logic gate_output_on_gain_lock;
  logic [1:0] min_modulation_depth;
  logic [3:0] z_sensitivity_cut;
  logic alert_source_select;

  assign auto_channel_pick = front_end_config_five[LFCS_AUTO_BIT];
  assign gate_output_on_gain_lock = front_end_config_five[LFCS_GATE_BIT];
  assign min_modulation_depth = front_end_config_five[LFCS_DEPTH_HI:LFCS_DEPTH_LO];
  assign z_sensitivity_cut = front_end_config_five[LFCS_ZCUT_HI:LFCS_ZCUT_LO];
  assign alert_source_select = lower_cfg[0][LFCS_ALERT_SEL_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage and its delay feed logic
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync_prev <= '0;
    end
    else if (ce)
    begin
      sync1 <= pins;
      sync2 <= sync1;
      sync_prev <= sync2;
    end
  end

  assign wake_rise = sync2.wake_hit & ~sync_prev.wake_hit;
  assign alarm_rise = sync2.alarm_expired & ~sync_prev.alarm_expired;
  assign stab_rise = sync2.stab_done & ~sync_prev.stab_done;
  assign status_read = rd_en && (addr == LFCS_ADDR_STATUS);

  //////////////////////////////////////////////////////////////////////////////
  // Register writes and reads
  always_comb
  begin
    next_cfg5 = front_end_config_five;
    next_col = column_check_bits;
    // Status has no write path at all
    if (wr_en && addr == LFCS_ADDR_CFG5) // [R16]
    begin
      next_cfg5 = wr_data;
    end
    if (wr_en && addr == LFCS_ADDR_COLCHK) // [R16]
    begin
      next_col = wr_data;
    end
    next_rd_data = rd_data;
    if (rd_en)
    begin
      case (addr)
        LFCS_ADDR_CFG5: next_rd_data = front_end_config_five;
        LFCS_ADDR_COLCHK: next_rd_data = column_check_bits;
        LFCS_ADDR_STATUS: next_rd_data = status; // [R16]
        default: next_rd_data = LFCS_READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      front_end_config_five <= LFCS_CFG5_RST;
      column_check_bits <= LFCS_COLCHK_RST;
      rd_data <= LFCS_READ_ZERO;
    end
    else if (ce)
    begin
      front_end_config_five <= next_cfg5;
      column_check_bits <= next_col;
      rd_data <= next_rd_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Odd parity over rows 0..6 and columns; host keeps words odd [R5] [R6] [R7]
  always_comb
  begin
    logic row_sum;
    logic [LFCS_W-1:0] col_sum;
    parity_bad = 1'b0;
    row_sum = 1'b0;
    col_sum = column_check_bits;
    for (int r = 0; r < LFCS_LOWER_REGS; r++)
    begin
      parity_bad = parity_bad | ~(^lower_cfg[r]); // [R18]
      col_sum = col_sum ^ lower_cfg[r];
      row_sum = row_sum ^ lower_cfg[r][LFCS_ROW_BIT];
    end
    parity_bad = parity_bad | ~(^front_end_config_five) | ~(^column_check_bits);
    col_sum = col_sum ^ front_end_config_five;
    row_sum = row_sum ^ front_end_config_five[LFCS_ROW_BIT];
    // Top column bit checks row bits, not bit 8 of the rows
    col_sum[LFCS_COL_TOP] = column_check_bits[LFCS_COL_TOP] ^ row_sum; // [R18]
    for (int b = LFCS_ROW_BIT + 1; b < LFCS_W; b++)
    begin
      parity_bad = parity_bad | ~col_sum[b]; // [R18]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel selection and status flags
  always_comb
  begin
    next_keep = channel_keep;
    if (!auto_channel_pick)
    begin
      next_keep = ~lower_cfg[0][LFCS_EN_HI:LFCS_EN_LO]; // [R1]
    end
    else if (stab_rise)
    begin
      next_keep = sync2.demod_high; // [R1]
    end
    next_status = status;
    // Passing and gain flags are live; soft reset zeroes them for each cycle that soft_reset is high
    {next_status.z_channel_passing, next_status.y_channel_passing,
     next_status.x_channel_passing} =
      channel_keep & sync2.chan_data & {3{sync2.gain_settled & ~standby}}; // [R8]
    next_status.gain_loop_active = sync2.gain_regulating; // [R9]
    if (soft_reset)
    begin
      next_status.z_channel_passing = 1'b0; // [R15]
      next_status.y_channel_passing = 1'b0;
      next_status.x_channel_passing = 1'b0;
      next_status.gain_loop_active = 1'b0; // [R15]
      next_status.z_woke_front_end = 1'b0; // [R15]
      next_status.y_woke_front_end = 1'b0;
      next_status.x_woke_front_end = 1'b0;
    end
    // Set after clear so a wake in the clearing cycle survives
    next_status.z_woke_front_end = next_status.z_woke_front_end | wake_rise[2]; // [R10]
    next_status.y_woke_front_end = next_status.y_woke_front_end | wake_rise[1]; // [R10]
    next_status.x_woke_front_end = next_status.x_woke_front_end | wake_rise[0]; // [R10]
    if (status_read)
    begin
      next_status.alarm = 1'b0; // [R14]
    end
    next_status.alarm = next_status.alarm | alarm_rise; // [R11]
    next_status.check_error_flag = parity_bad; // [R12]
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      channel_keep <= '0;
      status <= LFCS_STATUS_RST; // [R13]
    end
    else if (ce)
    begin
      channel_keep <= next_keep;
      status <= next_status; // sleep_cmd deliberately unused here [R14]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoded controls toward the analog side
  always_comb
  begin
    case (min_modulation_depth) // [R3]
      LFCS_DEPTH_C50: next_pct = LFCS_PCT_50;
      LFCS_DEPTH_C75: next_pct = LFCS_PCT_75;
      LFCS_DEPTH_C25: next_pct = LFCS_PCT_25;
      default: next_pct = LFCS_PCT_12;
    endcase
    next_cut = 5'(z_sensitivity_cut * LFCS_DB_PER_STEP); // [R4]
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      min_depth_pct <= LFCS_PCT_50;
      z_cut_db <= '0;
    end
    else if (ce)
    begin
      min_depth_pct <= next_pct;
      z_cut_db <= next_cut;
    end
  end

  assign demod_out_enable = ~gate_output_on_gain_lock | status.gain_loop_active; // [R2]
  assign alert_n = ~(status.check_error_flag | (alert_source_select & status.alarm)); // [R12] [R17]

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_ALARM_SET: assert property (@(posedge clk) disable iff (reset) // [R11]
    ce && alarm_rise |=> status.alarm)
    else $error("alarm flag missed timer expiry");
  AST_ALARM_READ: assert property (@(posedge clk) disable iff (reset) // [R14]
    ce && status_read && !alarm_rise |=> !status.alarm)
    else $error("status read did not clear alarm");
  AST_SOFT_CLEAR: assert property (@(posedge clk) disable iff (reset) // [R15]
    ce && soft_reset && wake_rise == 3'h0
    |=> status[8:2] == 7'h00 ##1 !ce || status[4:2] == 3'h0 || $past(wake_rise) != 3'h0)
    else $error("soft reset left channel flags set");
  AST_SOFT_KEEP: assert property (@(posedge clk) disable iff (reset) // [R15]
    ce && soft_reset && !status_read && !alarm_rise |=> $stable(status.alarm))
    else $error("soft reset disturbed the alarm flag");
  AST_PARITY: assert property (@(posedge clk) disable iff (reset) // [R12]
    ce |=> status.check_error_flag == $past(parity_bad))
    else $error("parity error flag lags the check");
  AST_ALERT: assert property (@(posedge clk) disable iff (reset) // [R17]
    status.alarm && alert_source_select |-> !alert_n)
    else $error("alarm did not reach alert");
  AST_CFG_WRITE: assert property (@(posedge clk) disable iff (reset) // [R16]
    ce && wr_en && addr == LFCS_ADDR_CFG5 |=> front_end_config_five == $past(wr_data))
    else $error("configuration write lost");
  AST_AUTO_PICK: assert property (@(posedge clk) disable iff (reset) // [R1]
    ce && auto_channel_pick && stab_rise |=> channel_keep == $past(sync2.demod_high))
    else $error("auto pick did not latch demodulator state");
  AST_GATE: assert property (@(posedge clk) disable iff (reset) // [R2]
    gate_output_on_gain_lock && !status.gain_loop_active |-> !demod_out_enable)
    else $error("output passed before gain lock");
  AST_DEPTH: assert property (@(posedge clk) disable iff (reset) // [R3]
    ce && min_modulation_depth == LFCS_DEPTH_C75 |=> min_depth_pct == LFCS_PCT_75)
    else $error("depth decode wrong");
  AST_ALERT_PARITY: assert property (@(posedge clk) disable iff (reset) // [R12]
    status.check_error_flag |-> !alert_n)
    else $error("parity error did not reach alert");
  AST_ALERT_QUIET: assert property (@(posedge clk) disable iff (reset) // [R17]
    !status.check_error_flag && !alert_source_select |-> alert_n)
    else $error("alert raised without a selected cause");
  AST_SLEEP_HOLD: assert property (@(posedge clk) disable iff (reset) // [R14]
    ce && sleep_cmd && !soft_reset && !status_read && wake_rise == 3'h0 && !alarm_rise
    |=> status[4:1] == $past(status[4:1]))
    else $error("sleep disturbed sticky status flags");
  AST_STANDBY: assert property (@(posedge clk) disable iff (reset) // [R8]
    ce && standby |=> status[8:6] == 3'h0)
    else $error("channel passing flag set in standby");
  AST_GAIN_LIVE: assert property (@(posedge clk) disable iff (reset) // [R9]
    ce && !soft_reset |=> status.gain_loop_active == $past(sync2.gain_regulating))
    else $error("gain loop flag does not follow the loop");
  COV_ALARM_READ: cover property (@(posedge clk) status.alarm ##1 status_read ##1 !status.alarm);
  COV_WAKE: cover property (@(posedge clk) disable iff (reset) |wake_rise ##1 soft_reset);
  COV_PARITY_OK: cover property (@(posedge clk) disable iff (reset) !status.check_error_flag);
  COV_AUTO_PICK: cover property (@(posedge clk) disable iff (reset)
    auto_channel_pick && stab_rise);
endmodule // lfcs_regs

// ---- test/lfcs_host.sv ----
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module lfcs_host
  import lfcs_pkg::*;
(
  input wire logic clk,
  output logic wr_en,
  output logic rd_en,
  output logic [3:0] addr,
  output logic [8:0] wr_data,
  input wire logic [8:0] rd_data
);
  initial
  begin
    {wr_en, rd_en, addr, wr_data} = '0;
  end
  function automatic logic [8:0] odd(input logic [8:1] u);
    return {u, ~^u};
  endfunction
  function automatic logic [8:0] colw(input logic [5:0][8:0] r);
    logic [8:1] c;
    c = '1;
    for (int i = 0; i < 6; i++)
    begin
      c[7:1] ^= r[i][7:1];
      c[8] ^= r[i][0];
    end
    return odd(c);
  endfunction
  // Idle bus shows inverted values, never the last ones
  task automatic wr(input logic [3:0] a, input logic [8:0] d);
    @(posedge clk);
    #1;
    {wr_en, addr, wr_data} = {1'b1, a, d};
    @(posedge clk);
    #1;
    {wr_en, addr, wr_data} = {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [3:0] a, output logic [8:0] d);
    @(posedge clk);
    #1;
    {rd_en, addr} = {1'b1, a};
    @(posedge clk);
    #1;
    {rd_en, addr} = {1'b0, ~a};
    d = rd_data;
  endtask
endmodule // lfcs_host

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module tb_top;
  import lfcs_pkg::*;
  logic clk = 0, reset = 1, ce = 1, srst = 0, slp = 0, stby = 0;
  logic wr_en, rd_en, den, alert_n;
  logic [3:0] addr;
  logic [8:0] wr_data, rd_data, v;
  logic [4:0][8:0] lc = {5{9'h001}};
  lfcs_pins_s pins = '0;
  logic [2:0] keep;
  logic [6:0] pct;
  logic [4:0] cut;
  lfcs_status_s st;
  logic [6:0] pt [4] = '{7'h32, 7'h4b, 7'h19, 7'h0c};
  int errors = 0, check_count = 0;
  always #5 clk = ~clk;
  lfcs_host h (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
    .rd_data(rd_data));
  lfcs_regs DUT (.clk(clk), .reset(reset), .ce(ce), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .lower_cfg(lc), .soft_reset(srst),
    .sleep_cmd(slp), .standby(stby), .pins(pins), .channel_keep(keep),
    .demod_out_enable(den), .min_depth_pct(pct), .z_cut_db(cut), .alert_n(alert_n),
    .status(st));
  //////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [8:0] e, input logic [8:0] s);
    check_count++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      errors++;
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Column word must follow every change of register 0 or 5
  task setup(input logic [8:0] c0, input logic [8:1] c5);
    lc[0] = c0;
    h.wr(4'h5, h.odd(c5));
    h.wr(4'h6, h.colw({h.odd(c5), lc}));
    cyc(3);
  endtask
  // Hang guard
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    final_report;
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(2);
    chk("por", 9'h001, st);
    chk("alert", 9'h000, 9'(alert_n));
    reset = 0;
    setup(9'h001, 8'h00);
    chk("clean", 9'h000, st);
    chk("alert", 9'h001, 9'(alert_n));
    for (int k = 0; k < 4; k++)
    begin
      setup(9'h001, {2'b00, 2'(k), 4'(5 * k)});
      chk("depth", 9'(pt[k]), 9'(pct));
      chk("cut", 9'(10 * k), 9'(cut));
      h.rd(4'h5, v);
      chk("cfg5", h.odd({2'b00, 2'(k), 4'(5 * k)}), v);
    end
    h.wr(4'h7, 9'h1fe);
    h.rd(4'h7, v);
    chk("ro", 9'h000, v);
    h.rd(4'h9, v);
    chk("unmapped", 9'h000, v);
    $display("test registers done");
    pins.chan_data = 3'h7;
    pins.gain_settled = 1'h1;
    pins.gain_regulating = 1'h1;
    setup(9'h004, 8'h00);
    chk("keep", 9'h005, 9'(keep));
    chk("pass", 9'h160, st);
    stby = 1;
    cyc(2);
    chk("standby", 9'h020, st);
    stby = 0;
    setup(9'h001, 8'h40);
    chk("gate", 9'h001, 9'(den));
    pins.gain_regulating = 1'h0;
    cyc(4);
    chk("gate", 9'h000, 9'(den));
    chk("gain", 9'h1c0, st);
    setup(9'h001, 8'h00);
    chk("nogate", 9'h001, 9'(den));
    pins.demod_high = 3'h5;
    setup(9'h001, 8'h80);
    pins.stab_done = 1'h1;
    cyc(4);
    chk("auto", 9'h005, 9'(keep));
    pins.stab_done = 1'h0;
    $display("test channels done");
    // Z and Y wake here, X later, so a swapped bit order shows
    setup(9'h010, 8'h00);
    pins.wake_hit = 3'h6;
    pins.alarm_expired = 1'h1;
    cyc(4);
    chk("event", 9'h1da, st);
    chk("alert", 9'h000, 9'(alert_n));
    pins.wake_hit = 3'h0;
    pins.alarm_expired = 1'h0;
    slp = 1;
    cyc(1);
    slp = 0;
    cyc(1);
    chk("sleep", 9'h1da, st);
    h.rd(4'h7, v);
    chk("rdst", 9'h1da, v);
    cyc(1);
    chk("rdclr", 9'h1d8, st);
    chk("alert", 9'h001, 9'(alert_n));
    setup(9'h001, 8'h00);
    pins.wake_hit = 3'h1;
    pins.alarm_expired = 1'h1;
    cyc(4);
    chk("alarm", 9'h1de, st);
    chk("alert", 9'h001, 9'(alert_n));
    srst = 1;
    cyc(1);
    srst = 0;
    chk("soft", 9'h002, st);
    $display("test events done");
    h.wr(4'h5, 9'h000);
    cyc(3);
    chk("perr", 9'h1c3, st);
    chk("alert", 9'h000, 9'(alert_n));
    reset = 1;
    cyc(1);
    chk("por2", 9'h001, st);
    // Pins idle before release, else a held pin reads as a fresh event
    pins = '0;
    reset = 0;
    cyc(2);
    chk("rerun", 9'h001, st);
    chk("rerun keep", 9'h007, 9'(keep));
    $display("test parity done");
    final_report;
  end
endmodule // tb_top
